// [design/host_port_pkg.sv]
package host_port_pkg;

    localparam int DATA_W    = 8;
    localparam int BIT_CNT_W = 3;
    localparam int BUSY_BIT  = 7;
    localparam int SI_BIT    = 7;
    localparam int SCL_BIT   = 6;

    localparam logic [2:0]        BIT_CNT_RESET = 3'h0;
    localparam logic [2:0]        BIT_CNT_LAST  = 3'h7;
    localparam logic [7:0]        BYTE_RESET    = 8'h00;
    localparam logic [7:0]        DRIVE_ALL     = 8'hFF;
    localparam logic [7:0]        DRIVE_NONE    = 8'h00;
    localparam int                CTL_W         = 4;
    localparam int                STB_W         = 2;
    localparam int                MODE_W        = 2;
    localparam logic [3:0]        CTL_RESET     = 4'h8;
    localparam logic [1:0]        STB_RESET     = 2'h3;
    localparam logic [1:0]        MODE_RESET    = 2'h0;

    typedef enum logic [1:0] {
        XFER_DATA_READ,
        XFER_DATA_WRITE,
        XFER_STATUS_READ,
        XFER_COMMAND_WRITE
    } xfer_kind_t;

    // Byte handed to the core, one-cycle valid
    typedef struct packed {
        logic       valid;
        logic       is_data;
        logic [7:0] byte_val;
    } core_write_t;

    // Strobe pins of the parallel bus
    typedef struct packed {
        logic rd_e;
        logic wr_rw;
    } strobe_pins_t;

endpackage

// [design/host_port.sv]
`timescale 1ns/1ps
// Operation
// - Interface select high: 8-bit parallel bus
// - Serial: D7 data, D6 clock, rest floating
// - Access only when selects low/high
// - Deselected: float bus, ignore strobes
// - Select high means data, low command
// - Reset input initializes by level
// - Style select high 68, low 80
// - 80-style: drive bus while read low
// - 80-style: latch write on leading edge
// - 68-style: enable clock, direction high reads
// - Decode data/status read, data/command write
// - Serial: 8-bit shifter, 3-bit counter
// - MSB first, byte on eighth rise
// - Sample select at each eighth rise
// - Deselect resets shifter and counter
// - Serial mode is write-only
// - Busy on bit 7; only status while busy (serial mode still takes writes while busy)
// - Data reads pass a holding register
module host_port (
    input  wire logic                        clk,
    input  wire logic                        rst,
    input  wire logic                        reset_in_n,
    input  wire logic                        parallel_select,
    input  wire logic                        bus_style_select,
    input  wire logic                        chip_select_low_active,
    input  wire logic                        chip_select_high_active,
    input  wire logic                        data_command_select,
    input  wire host_port_pkg::strobe_pins_t strobe_pins,
    input  wire logic [7:0]                  data_in,
    output logic [7:0]                       data_out,
    output logic [7:0]                       data_oe,
    input  wire logic                        core_busy,
    input  wire logic [7:0]                  core_status,
    input  wire logic [7:0]                  core_read_data,
    output logic                             core_read_req,
    output host_port_pkg::core_write_t       core_write,
    output logic                             core_reset
);
    import host_port_pkg::*;

    // Two-stage synchronisers for all pin inputs
    logic [7:0]   data_sync;
    logic [3:0]   ctl_sync;
    logic [1:0]   stb_sync;
    logic [1:0]   mode_sync;

    host_port_sync #(
        .W         (DATA_W),
        .RESET_VAL (BYTE_RESET)
    ) u_data_sync (
        .clk (clk),
        .rst (rst),
        .d   (data_in),
        .q   (data_sync)
    );

    host_port_sync #(
        .W         (CTL_W),
        .RESET_VAL (CTL_RESET)
    ) u_ctl_sync (
        .clk (clk),
        .rst (rst),
        .d   ({reset_in_n, chip_select_low_active, chip_select_high_active, data_command_select}),
        .q   (ctl_sync)
    );

    host_port_sync #(
        .W         (STB_W),
        .RESET_VAL (STB_RESET)
    ) u_stb_sync (
        .clk (clk),
        .rst (rst),
        .d   ({strobe_pins.rd_e, strobe_pins.wr_rw}),
        .q   (stb_sync)
    );

    host_port_sync #(
        .W         (MODE_W),
        .RESET_VAL (MODE_RESET)
    ) u_mode_sync (
        .clk (clk),
        .rst (rst),
        .d   ({parallel_select, bus_style_select}),
        .q   (mode_sync)
    );

    logic pin_reset_n, pin_cs_l, pin_cs_h, pin_dc, pin_rd_e, pin_wr_rw, is_parallel, is_68;
    logic selected, in_reset;

    always_comb begin
        pin_reset_n = ctl_sync[3];
        pin_cs_l    = ctl_sync[2];
        pin_cs_h    = ctl_sync[1];
        pin_dc      = ctl_sync[0];
        pin_rd_e    = stb_sync[1];
        pin_wr_rw   = stb_sync[0];
        is_parallel = mode_sync[1];
        is_68       = mode_sync[0];
        in_reset    = !pin_reset_n;
        selected    = !pin_cs_l && pin_cs_h && !in_reset;
    end

    // Previous strobe and serial clock levels for edge detection
    logic       prev_rd_ff, prev_wr_ff, prev_scl_ff;
    logic       nxt_prev_rd, nxt_prev_wr, nxt_prev_scl;
    logic       rd_active, wr_active, rd_start, wr_start, scl_rise;

    always_comb begin
        nxt_prev_rd  = pin_rd_e;
        nxt_prev_wr  = pin_wr_rw;
        nxt_prev_scl = data_sync[SCL_BIT];
        if (is_68) begin
            // Enable high opens the cycle, direction picks read or write
            rd_active = pin_rd_e && pin_wr_rw;
            wr_active = pin_rd_e && !pin_wr_rw;
            rd_start  = pin_rd_e && !prev_rd_ff && pin_wr_rw;
            wr_start  = pin_rd_e && !prev_rd_ff && !pin_wr_rw;
        end else begin
            rd_active = !pin_rd_e;
            wr_active = !pin_wr_rw;
            rd_start  = !pin_rd_e && prev_rd_ff;
            wr_start  = !pin_wr_rw && prev_wr_ff;
        end
        scl_rise = data_sync[SCL_BIT] && !prev_scl_ff;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            prev_rd_ff  <= 1'b1;
            prev_wr_ff  <= 1'b1;
            prev_scl_ff <= 1'b0;
        end else begin
            prev_rd_ff  <= nxt_prev_rd;
            prev_wr_ff  <= nxt_prev_wr;
            prev_scl_ff <= nxt_prev_scl;
        end
    end

    xfer_kind_t kind;

    always_comb begin
        if (pin_dc && rd_active)
            kind = XFER_DATA_READ;
        else if (pin_dc)
            kind = XFER_DATA_WRITE;
        else if (rd_active)
            kind = XFER_STATUS_READ;
        else
            kind = XFER_COMMAND_WRITE;
    end

    // Transfer state
    logic [7:0]     shift_ff, nxt_shift;
    logic [2:0]     bit_cnt_ff, nxt_bit_cnt;
    logic [7:0]     hold_ff, nxt_hold;
    logic [7:0]     dout_ff, nxt_dout;
    logic [7:0]     oe_ff, nxt_oe;
    logic           rreq_ff, nxt_rreq;
    logic           rreq_d_ff, nxt_rreq_d;
    core_write_t    wr_ff, nxt_wr;
    logic           creset_ff, nxt_creset;

    // Serial shifter and bit counter
    always_comb begin
        nxt_shift   = shift_ff;
        nxt_bit_cnt = bit_cnt_ff;
        if (!selected) begin
            nxt_shift   = BYTE_RESET;
            nxt_bit_cnt = BIT_CNT_RESET;
        end else if (!is_parallel && scl_rise) begin
            nxt_shift   = {shift_ff[DATA_W-2:0], data_sync[SI_BIT]};
            nxt_bit_cnt = bit_cnt_ff + 3'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            shift_ff   <= BYTE_RESET;
            bit_cnt_ff <= BIT_CNT_RESET;
        end else begin
            shift_ff   <= nxt_shift;
            bit_cnt_ff <= nxt_bit_cnt;
        end
    end

    // Parallel read path and holding register
    always_comb begin
        nxt_hold   = hold_ff;
        nxt_dout   = dout_ff;
        nxt_oe     = DRIVE_NONE;
        nxt_rreq   = 1'b0;
        nxt_rreq_d = rreq_ff;
        if (rreq_d_ff)
            nxt_hold = core_read_data;
        if (selected && is_parallel && rd_active) begin
            nxt_oe   = DRIVE_ALL;
            nxt_dout = (kind == XFER_STATUS_READ) ?
                       {core_busy, core_status[BUSY_BIT-1:0]} : hold_ff;
            if (rd_start && kind == XFER_DATA_READ && !core_busy)
                nxt_rreq = 1'b1;
        end
        if (in_reset) begin
            nxt_hold   = BYTE_RESET;
            nxt_rreq_d = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            hold_ff   <= BYTE_RESET;
            dout_ff   <= BYTE_RESET;
            oe_ff     <= DRIVE_NONE;
            rreq_ff   <= 1'b0;
            rreq_d_ff <= 1'b0;
        end else begin
            hold_ff   <= nxt_hold;
            dout_ff   <= nxt_dout;
            oe_ff     <= nxt_oe;
            rreq_ff   <= nxt_rreq;
            rreq_d_ff <= nxt_rreq_d;
        end
    end

    // Byte hand-over to the core
    always_comb begin
        nxt_wr = '{valid: 1'b0, is_data: 1'b0, byte_val: BYTE_RESET};
        if (selected && is_parallel) begin
            if (!rd_active && wr_start && wr_active && !core_busy)
                nxt_wr = '{valid: 1'b1, is_data: (kind == XFER_DATA_WRITE), byte_val: data_sync};
        end else if (selected && scl_rise && bit_cnt_ff == BIT_CNT_LAST) begin
            nxt_wr = '{valid: 1'b1, is_data: pin_dc,
                       byte_val: {shift_ff[DATA_W-2:0], data_sync[SI_BIT]}};
        end
    end

    always_ff @(posedge clk) begin
        if (rst)
            wr_ff <= '0;
        else
            wr_ff <= nxt_wr;
    end

    // Core reset follows the reset pin level
    always_comb begin
        nxt_creset = in_reset;
    end

    always_ff @(posedge clk) begin
        if (rst)
            creset_ff <= 1'b1;
        else
            creset_ff <= nxt_creset;
    end

    always_comb begin
        data_out      = dout_ff;
        data_oe       = oe_ff;
        core_read_req = rreq_ff;
        core_write    = wr_ff;
        core_reset    = creset_ff;
    end

endmodule

module host_port_sync #(
    parameter int           W         = 1,
    parameter logic [W-1:0] RESET_VAL = '0
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic [W-1:0]      q
);
    logic [W-1:0] stage1_ff, stage2_ff;
    logic [W-1:0] nxt_stage1, nxt_stage2;

    always_comb begin
        nxt_stage1 = d;
        nxt_stage2 = stage1_ff;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            stage1_ff <= RESET_VAL;
            stage2_ff <= RESET_VAL;
        end else begin
            stage1_ff <= nxt_stage1;
            stage2_ff <= nxt_stage2;
        end
    end

    always_comb begin
        q = stage2_ff;
    end

endmodule

// [tb/host_port_assertions.sv]
`timescale 1ns/1ps
module host_port_assertions (
    input wire logic                        clk,
    input wire logic                        rst,
    input wire logic                        reset_in_n,
    input wire logic                        parallel_select,
    input wire logic                        bus_style_select,
    input wire logic                        chip_select_low_active,
    input wire logic                        chip_select_high_active,
    input wire logic                        data_command_select,
    input wire host_port_pkg::strobe_pins_t strobe_pins,
    input wire logic [7:0]                  data_oe,
    input wire logic                        core_busy,
    input wire logic                        core_read_req,
    input wire host_port_pkg::core_write_t  core_write,
    input wire logic                        core_reset
);
    import host_port_pkg::*;
    wire logic act = !chip_select_low_active && chip_select_high_active;
    wire logic sel = act && parallel_select && !core_reset;
    wire logic s80 = sel && !bus_style_select;
    wire logic s68 = sel && bus_style_select;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence oe_all;
        ##[3:4] data_oe == 8'hFF;
    endsequence
    sequence wr_seen;
        ##[3:4] core_write.valid;
    endsequence
    desel_float_a: assert property ((!act) [*5] |-> data_oe == 8'h00)
        else $error("bus driven while deselected");
    serial_float_a: assert property ((!parallel_select) [*5] |-> data_oe == 8'h00)
        else $error("bus driven in serial mode");
    rd80_drive_a: assert property (s80 && $fell(strobe_pins.rd_e) |-> oe_all)
        else $error("read strobe not answered");
    wr80_take_a: assert property (s80 && !core_busy && $fell(strobe_pins.wr_rw) |-> wr_seen)
        else $error("write strobe not captured");
    e68_write_a: assert property (s68 && !core_busy && !strobe_pins.wr_rw && $rose(strobe_pins.rd_e) |-> wr_seen)
        else $error("enable write not captured");
    e68_read_a: assert property (s68 && strobe_pins.wr_rw && $rose(strobe_pins.rd_e) |-> oe_all)
        else $error("enable read not answered");
    byte_pulse_a: assert property (core_write.valid |=> !core_write.valid)
        else $error("byte valid too long");
    kind_match_a: assert property (core_write.valid |-> core_write.is_data == data_command_select)
        else $error("byte kind wrong");
    req_data_a: assert property (core_read_req |-> data_command_select)
        else $error("read request on status");
    reset_level_a: assert property ((!reset_in_n) [*4] |-> core_reset)
        else $error("reset level not held");
endmodule
bind host_port host_port_assertions u_host_port_assertions (.*);

// [tb/host_model.sv]
`timescale 1ns/1ps
module host_model (
    input  wire logic                   clk,
    input  wire logic [7:0]             pin_level,
    output logic                        dcs,
    output host_port_pkg::strobe_pins_t pins,
    output logic [7:0]                  drv
);
    import host_port_pkg::*;
    initial begin
        dcs = 1'b0;
        pins = 2'b11;
        drv = 8'h00;
    end
    task automatic idle(input logic st);
        pins <= '{rd_e: !st, wr_rw: 1'b1};
    endtask
    task automatic xfer(input logic st, rd, a0, input logic [7:0] v, output logic [7:0] got);
        dcs <= a0;
        drv <= v;
        pins <= '{rd_e: st | !rd, wr_rw: rd};
        repeat (5) @(posedge clk);
        got = pin_level;
        idle(st);
        drv <= ~v;
        repeat (5) @(posedge clk);
    endtask
    task automatic ser_bits(input logic a0, input logic [7:0] v, input int n);
        dcs <= a0;
        drv <= 8'h00;
        repeat (3) @(posedge clk);
        for (int i = 7; i > 7 - n; i--) begin
            drv[7] <= v[i];
            repeat (4) @(posedge clk);
            drv[6] <= 1'b1;
            repeat (4) @(posedge clk);
            drv[6] <= 1'b0;
        end
        repeat (4) @(posedge clk);
    endtask
endmodule

// [tb/testbench.sv]
`timescale 1ns/1ps
module testbench;
    import host_port_pkg::*;
    logic         clk, rst, reset_in_n, parallel_select, bus_style_select, core_busy;
    logic         chip_select_low_active, chip_select_high_active, data_command_select;
    logic         core_read_req, core_reset;
    logic [7:0]   data_in, data_out, data_oe, core_status, core_read_data, drv, got, nxt_rd;
    logic [8:0]   wlast;
    strobe_pins_t strobe_pins;
    core_write_t  core_write;
    int           fails, checks_done, wcnt, cyc;
    assign data_in = (data_oe & data_out) | (~data_oe & drv);
    host_port u_host_port (
        .clk                     (clk),
        .rst                     (rst),
        .reset_in_n              (reset_in_n),
        .parallel_select         (parallel_select),
        .bus_style_select        (bus_style_select),
        .chip_select_low_active  (chip_select_low_active),
        .chip_select_high_active (chip_select_high_active),
        .data_command_select     (data_command_select),
        .strobe_pins             (strobe_pins),
        .data_in                 (data_in),
        .data_out                (data_out),
        .data_oe                 (data_oe),
        .core_busy               (core_busy),
        .core_status             (core_status),
        .core_read_data          (core_read_data),
        .core_read_req           (core_read_req),
        .core_write              (core_write),
        .core_reset              (core_reset)
    );
    host_model u_host_model (.clk(clk), .pin_level(data_in), .dcs(data_command_select),
        .pins(strobe_pins), .drv(drv));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic chk(input string nm, input logic [8:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (core_read_req) begin
            core_read_data <= nxt_rd;
            nxt_rd <= nxt_rd + 8'h01;
        end
        if (core_write.valid) begin
            wcnt++;
            wlast <= {core_write.is_data, core_write.byte_val};
        end
        if (cyc == 3000) begin
            fails++;
            end_sim;
        end
    end
    initial begin
        {rst, reset_in_n, parallel_select, bus_style_select, core_busy} = 5'b11100;
        {chip_select_low_active, chip_select_high_active} = 2'b01;
        core_status = 8'h2C;
        core_read_data = 8'h00;
        nxt_rd = 8'h5A;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (6) @(posedge clk);
        u_host_model.xfer(0, 0, 0, 8'hC3, got);
        chk("cmd_wr", wlast, 9'h0C3);
        u_host_model.xfer(0, 0, 1, 8'h3C, got);
        chk("dat_wr", wlast, 9'h13C);
        u_host_model.xfer(0, 1, 0, 8'h00, got);
        chk("status", {1'b0, got}, 9'h02C);
        u_host_model.xfer(0, 1, 1, 8'h00, got);
        u_host_model.xfer(0, 1, 1, 8'h00, got);
        chk("dat_rd", {1'b0, got}, 9'h05A);
        core_busy <= 1'b1;
        u_host_model.xfer(0, 0, 1, 8'h77, got);
        u_host_model.xfer(0, 1, 0, 8'h00, got);
        chk("busy_st", {1'b0, got}, 9'h0AC);
        core_busy <= 1'b0;
        chip_select_low_active <= 1'b1;
        u_host_model.xfer(0, 0, 1, 8'h11, got);
        {chip_select_low_active, chip_select_high_active} <= 2'b00;
        u_host_model.xfer(0, 1, 0, 8'h00, got);
        chk("desel_rd", {1'b0, got}, 9'h000);
        chk("wr_cnt", 9'(wcnt), 9'h002);
        bus_style_select <= 1'b1;
        u_host_model.idle(1);
        repeat (5) @(posedge clk);
        chip_select_high_active <= 1'b1;
        repeat (5) @(posedge clk);
        u_host_model.xfer(1, 0, 0, 8'hA5, got);
        chk("w68", wlast, 9'h0A5);
        u_host_model.xfer(1, 1, 1, 8'h00, got);
        chk("r68", {1'b0, got}, 9'h05B);
        parallel_select <= 1'b0;
        u_host_model.ser_bits(1, 8'h00, 3);
        chip_select_low_active <= 1'b1;
        repeat (4) @(posedge clk);
        chip_select_low_active <= 1'b0;
        u_host_model.ser_bits(1, 8'h96, 8);
        chk("ser_dat", wlast, 9'h196);
        u_host_model.ser_bits(0, 8'h4B, 8);
        chk("ser_cmd", wlast, 9'h04B);
        chk("ser_cnt", 9'(wcnt), 9'h005);
        reset_in_n <= 1'b0;
        repeat (5) @(posedge clk);
        chk("res_lo", {8'h00, core_reset}, 9'h001);
        reset_in_n <= 1'b1;
        repeat (8) @(posedge clk);
        chk("res_hi", {8'h00, core_reset}, 9'h000);
        end_sim;
    end
endmodule
